// >>> bench/cds_link_model.sv
`timescale 1ns/1ps
module cds_link_model (
   input logic sys_clk,
   output logic reg_wr, reg_rd,
   output logic [5:0] reg_addr,
   output logic [7:0] reg_wdata,
   input logic [7:0] reg_rdata
);
   initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 16'h0;
   // one access per two cycles; write data inverted after so stale bytes never pass
   task xfer(input logic w, input logic [5:0] a, input logic [7:0] wd, output logic [7:0] rd);
      @(negedge sys_clk);
      {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, wd};
      @(negedge sys_clk);
      {reg_wr, reg_rd, reg_wdata} = {2'h0, ~wd};
      rd = reg_rdata;
   endtask
endmodule // cds_link_model

// >>> bench/cds_phy_regs_assertions.sv
`timescale 1ns/1ps
module cds_chk (
   input logic sys_clk, reset_n, sync_mode, session_irq, reg_wr, reg_rd,
   input logic line_state_bit0, line_state_bit1, chg_pullup_pos, chg_pullup_neg,
   input logic [5:0] reg_addr,
   input logic [7:0] reg_wdata, reg_rdata, ulpi_data_out
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   wire rd36 = reg_rd && reg_addr == 6'h36;
   wire set3a = reg_wr && reg_addr == 6'h3a;
   a_irq_line: assert property (##1 ulpi_data_out[3] ==
      ($past(session_irq) && !$past(sync_mode))) else $error("irq");
   a_line_state: assert property (##1 ulpi_data_out[1:0] ==
      {$past(line_state_bit1), $past(line_state_bit0)}) else $error("ls");
   a_pos_set: assert property (set3a && reg_wdata[4] |=> chg_pullup_pos)
      else $error("pos");
   a_neg_set: assert property (set3a && reg_wdata[5] |=> chg_pullup_neg)
      else $error("neg");
   a_neg_alone: assert property (set3a && !reg_wdata[5] |=> $stable(chg_pullup_neg))
      else $error("indep");
   a_rid_upper: assert property (rd36 |=> !reg_rdata[7] && !reg_rdata[5]) else $error("rid");
   a_start_clear: assert property (rd36 ##1 reg_rdata[3] |-> !reg_rdata[4])
      else $error("start");
   a_done_clear: assert property (rd36 ##1 !reg_rdata[4] ##1 rd36 |=> !reg_rdata[3])
      else $error("done");
   c_pos: cover property (set3a && reg_wdata[4]);
   c_done: cover property (rd36 ##1 reg_rdata[3]);
   c_irq: cover property (ulpi_data_out[3]);
endmodule // cds_chk

// >>> bench/cds_phy_regs_tb.sv
`timescale 1ns/1ps
module cds_phy_regs_tb;
   logic sys_clk = 0, reset_n = 0, sync_mode = 0, session_valid = 0, session_irq = 0;
   logic line_state_bit0 = 0, line_state_bit1 = 0, id_ground_seen = 0;
   logic [2:0] rid_measured = 3'h0;
   logic reg_wr, reg_rd, chg_pullup_pos, chg_pullup_neg, id_pull_up_enable;
   logic [5:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, ulpi_data_out, func_ctrl, d;
   int fails = 0, cmp_count = 0;
   wire [7:0] pu = {6'h0, chg_pullup_neg, chg_pullup_pos};
   always #50 sys_clk = ~sys_clk;
   cds_phy_regs #(.CONV_CYCLES(8)) u_dut (
      .sys_clk(sys_clk), .reset_n(reset_n), .sync_mode(sync_mode),
      .session_valid(session_valid), .session_irq(session_irq),
      .line_state_bit0(line_state_bit0), .line_state_bit1(line_state_bit1),
      .id_ground_seen(id_ground_seen), .rid_measured(rid_measured),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .ulpi_data_out(ulpi_data_out),
      .chg_pullup_pos(chg_pullup_pos), .chg_pullup_neg(chg_pullup_neg),
      .id_pull_up_enable(id_pull_up_enable), .func_ctrl(func_ctrl));
   cds_link_model u_link (
      .sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   task chk(input logic [7:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task final_report;
      $display("cmp_count=%0d fails=%0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task t_reset;
      repeat (20) @(negedge sys_clk);
      reset_n = 1;
      chk(func_ctrl, 8'h41);
   endtask
   task t_detect;
      session_valid = 1;
      u_link.xfer(1, 6'h04, 8'h49, d);
      chk(func_ctrl, 8'h49);
      u_link.xfer(1, 6'h3a, 8'h10, d);
      chk(pu, 8'h01);
      u_link.xfer(1, 6'h3a, 8'h20, d);
      chk(pu, 8'h03);
      {session_irq, line_state_bit1, line_state_bit0} = 3'h7;
      @(negedge sys_clk);
      chk(ulpi_data_out, 8'h0b);
      {sync_mode, line_state_bit1, line_state_bit0} = 3'h4;
      u_link.xfer(0, 6'h39, 8'h00, d);
      chk(d, 8'h34);
      chk(ulpi_data_out, 8'h00);
      sync_mode = 0;
      u_link.xfer(1, 6'h3b, 8'h30, d);
      u_link.xfer(1, 6'h04, 8'h41, d);
      chk(pu, 8'h00);
      chk(func_ctrl, 8'h41);
   endtask
   task t_rid;
      chk({7'h0, id_pull_up_enable}, 8'h00);
      {id_ground_seen, rid_measured} = 4'ha;
      u_link.xfer(1, 6'h37, 8'h10, d);
      chk({7'h0, id_pull_up_enable}, 8'h01);
      d = 8'h0;
      for (int i = 0; i < 20 && d[3] !== 1'b1; i++) u_link.xfer(0, 6'h36, 8'h0, d);
      chk(d, 8'h0a);
      u_link.xfer(0, 6'h36, 8'h0, d);
      chk(d, 8'h02);
   endtask
   task t_regs;
      u_link.xfer(1, 6'h05, 8'h08, d);
      chk(func_ctrl, 8'h49);
      u_link.xfer(1, 6'h06, 8'h08, d);
      chk(func_ctrl, 8'h41);
      u_link.xfer(1, 6'h39, 8'h02, d);
      u_link.xfer(0, 6'h3b, 8'h00, d);
      chk(d, 8'h02);
      u_link.xfer(1, 6'h36, 8'h40, d);
      u_link.xfer(0, 6'h38, 8'h00, d);
      chk(d, 8'h42);
      u_link.xfer(1, 6'h38, 8'h40, d);
      u_link.xfer(0, 6'h10, 8'h00, d);
      chk(d, 8'h00);
   endtask
   initial begin
      t_reset;
      t_detect;
      t_rid;
      t_regs;
      final_report;
   end
   initial begin
      #400000;
      fails++;
      final_report;
   end
endmodule // cds_phy_regs_tb
bind cds_phy_regs cds_chk u_chk (.*);

// >>> common/cds_map.vh
// Function
// - outside synchronous mode the transceiver shows its interrupt on data line 3 for the link.
// - setting bit 4 through set address 3Ah connects the positive-line charger pull-up.
// - writing 20h to set address 3Ah connects the negative-line pull-up, independently.
// - outside synchronous mode the transceiver shows the two line state bits on data 0 and 1.
// - the id resistor code is 3 bits and 100 kohm to ground reads 010.
// - the conversion done flag clears when the id conversion register is read.
// - the conversion start bit clears once the conversion has completed.
`ifndef CDS_MAP_VH
`define CDS_MAP_VH
`define CDS_ADDR_FUNC_CTRL 6'h04
`define CDS_ADDR_FUNC_SET 6'h05
`define CDS_ADDR_FUNC_CLR 6'h06
`define CDS_ADDR_RID_WR 6'h36
`define CDS_ADDR_RID_SET 6'h37
`define CDS_ADDR_RID_CLR 6'h38
`define CDS_ADDR_IOPM_WR 6'h39
`define CDS_ADDR_IOPM_SET 6'h3a
`define CDS_ADDR_IOPM_CLR 6'h3b
`define CDS_FUNC_RESET 8'h41
`define CDS_IOPM_RESET 8'h04
`define CDS_RID_RESET 8'h00
`define CDS_BIT_PU_POS 4
`define CDS_BIT_PU_NEG 5
`define CDS_BIT_RID_DONE 3
`define CDS_BIT_RID_START 4
`define CDS_RID_100K 3'h2
`define CDS_CONV_TIME_US 282
`define CDS_CLK_MHZ 10
`define CDS_CONV_CYCLES (`CDS_CONV_TIME_US * `CDS_CLK_MHZ)
`endif

// >>> core/cds_phy_regs.v
`timescale 1ns/1ps
`include "cds_map.vh"
module cds_phy_regs #(
   parameter CONV_CYCLES = `CDS_CONV_CYCLES
) (
   input wire sys_clk,
   input wire reset_n,
   input wire sync_mode,
   input wire session_valid,
   input wire session_irq,
   input wire line_state_bit0,
   input wire line_state_bit1,
   input wire id_ground_seen,
   input wire [2:0] rid_measured,
   input wire reg_wr,
   input wire reg_rd,
   input wire [5:0] reg_addr,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   output reg [7:0] ulpi_data_out,
   output reg chg_pullup_pos,
   output reg chg_pullup_neg,
   output reg id_pull_up_enable,
   output reg [7:0] func_ctrl
);
   reg [7:0] iopm;
   reg [7:0] rid;
   reg [2:0] id_resistor_code;
   reg id_conv_done;
   reg id_conv_start;
   reg [12:0] conv_cnt;
   wire conv_end;
   wire rid_read;
   reg [7:0] next_iopm;
   reg [7:0] next_rid;
   reg [7:0] next_func;
   wire [31:0] conv_full;
   wire [12:0] conv_load;
   wire start_load;

   // write, set and clear share one decode for the io and id triplets; function control write takes the byte directly
   function [7:0] wsc;
      input [7:0] cur;
      input [7:0] wd;
      input [1:0] kind;
      begin
         case (kind)
            2'd0: wsc = wd;
            2'd1: wsc = cur | wd;
            2'd2: wsc = cur & ~wd;
            default: wsc = cur;
         endcase
      end
   endfunction

   assign conv_end = id_conv_start && (conv_cnt == 13'd1);
   assign rid_read = reg_rd && (reg_addr >= `CDS_ADDR_RID_WR) && (reg_addr <= `CDS_ADDR_RID_CLR);
   // the counter is 13 bits, enough for the full conversion time
   assign conv_full = CONV_CYCLES;
   assign conv_load = conv_full[12:0];
   assign start_load = !id_conv_start && next_rid[`CDS_BIT_RID_START];

   always @* begin
      next_func = func_ctrl;
      next_iopm = iopm;
      next_rid = rid;
      if (reg_wr) begin
         case (reg_addr)
            `CDS_ADDR_FUNC_CTRL: next_func = reg_wdata;
            `CDS_ADDR_FUNC_SET: next_func = wsc(func_ctrl, reg_wdata, 2'd1);
            `CDS_ADDR_FUNC_CLR: next_func = wsc(func_ctrl, reg_wdata, 2'd2);
            `CDS_ADDR_IOPM_WR: next_iopm = wsc(iopm, reg_wdata, 2'd0);
            `CDS_ADDR_IOPM_SET: next_iopm = wsc(iopm, reg_wdata, 2'd1);
            `CDS_ADDR_IOPM_CLR: next_iopm = wsc(iopm, reg_wdata, 2'd2);
            `CDS_ADDR_RID_WR: next_rid = wsc(rid, reg_wdata, 2'd0);
            `CDS_ADDR_RID_SET: next_rid = wsc(rid, reg_wdata, 2'd1);
            `CDS_ADDR_RID_CLR: next_rid = wsc(rid, reg_wdata, 2'd2);
            default: next_rid = rid;
         endcase
      end
      // reserved bits stay zero whatever the host writes
      next_iopm = next_iopm & 8'hfe;
      next_rid = next_rid & 8'h50;
   end

   // every address of a triplet reads the same register
   function [7:0] read_mux;
      input [5:0] addr;
      input [7:0] fc;
      input [7:0] io;
      input [7:0] rv;
      input done;
      input [2:0] code;
      begin
         case (addr)
            `CDS_ADDR_FUNC_CTRL, `CDS_ADDR_FUNC_SET, `CDS_ADDR_FUNC_CLR: begin
               read_mux = fc;
            end
            `CDS_ADDR_IOPM_WR, `CDS_ADDR_IOPM_SET, `CDS_ADDR_IOPM_CLR: begin
               read_mux = io;
            end
            `CDS_ADDR_RID_WR, `CDS_ADDR_RID_SET, `CDS_ADDR_RID_CLR: begin
               read_mux = {rv[7:4], done, code};
            end
            default: begin
               read_mux = 8'h00;
            end
         endcase
      end
   endfunction

   // function control and io power management registers
   always @(posedge sys_clk) begin
      if (!reset_n) begin
         func_ctrl <= `CDS_FUNC_RESET;
         iopm <= `CDS_IOPM_RESET;
      end else begin
         func_ctrl <= next_func;
         iopm <= next_iopm;
      end
   end

   // completion drops the start bit even against a host write in that cycle
   always @(posedge sys_clk) begin
      if (!reset_n) begin
         rid <= `CDS_RID_RESET;
      end else if (conv_end) begin
         rid <= next_rid & ~(8'h01 << `CDS_BIT_RID_START);
      end else begin
         rid <= next_rid;
      end
   end

   // pull-ups follow the register bits one cycle after the write
   always @(posedge sys_clk) begin
      if (!reset_n) begin
         chg_pullup_pos <= 1'b0;
         chg_pullup_neg <= 1'b0;
      end else begin
         chg_pullup_pos <= next_iopm[`CDS_BIT_PU_POS];
         chg_pullup_neg <= next_iopm[`CDS_BIT_PU_NEG];
      end
   end

   // biased on id ground too, so the converter never sees a floating pin
   always @(posedge sys_clk) begin
      if (!reset_n) begin
         id_pull_up_enable <= 1'b0;
      end else begin
         id_pull_up_enable <= id_ground_seen | next_rid[`CDS_BIT_RID_START];
      end
   end

   // conversion timer: start bit follows the register until completion
   always @(posedge sys_clk) begin
      if (!reset_n) begin
         id_conv_start <= 1'b0;
         conv_cnt <= 13'd0;
      end else begin
         if (conv_end) begin
            id_conv_start <= 1'b0;
         end else begin
            id_conv_start <= next_rid[`CDS_BIT_RID_START];
         end
         if (start_load) begin
            conv_cnt <= conv_load;
         end else if (conv_cnt != 13'd0) begin
            conv_cnt <= conv_cnt - 13'd1;
         end
      end
   end

   // completion wins over a read in the same cycle
   always @(posedge sys_clk) begin
      if (!reset_n) begin
         id_resistor_code <= 3'h0;
         id_conv_done <= 1'b0;
      end else begin
         if (conv_end) begin
            id_resistor_code <= rid_measured;
            id_conv_done <= 1'b1;
         end else if (rid_read) begin
            id_conv_done <= 1'b0;
         end
      end
   end

   // read data lags the address by one cycle
   always @(posedge sys_clk) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= read_mux(reg_addr, func_ctrl, iopm, rid, id_conv_done, id_resistor_code);
      end
   end

   // low power data bus: line state on 0/1, interrupt on 3 outside sync mode only
   always @(posedge sys_clk) begin
      if (!reset_n) begin
         ulpi_data_out <= 8'h00;
      end else if (sync_mode) begin
         ulpi_data_out <= {6'h00, line_state_bit1, line_state_bit0};
      end else begin
         ulpi_data_out <= {4'h0, session_irq, 1'b0, line_state_bit1, line_state_bit0};
      end
   end
endmodule // cds_phy_regs
